// >>> rtl/irecfg_top.sv
// ir engine configuration registers with engine mirror and turnaround timer
`timescale 1ns/1ps
module irecfg_top (
	input wire logic ref_clk,
	input wire logic reset_n,
	input irecfg_pkg::irecfg_cfg_req_t cfg_req,
	input irecfg_pkg::irecfg_eng_req_t eng_req,
	input wire logic eng_soft_reset,
	input wire logic eng_dma_req,
	input wire logic turnaround_start,
	output logic [7:0] cfg_rdata_q,
	output logic [7:0] eng_rdata_q,
	output logic [7:0] turnaround_timeout_q,
	output logic [7:0] sw_select_a_q,
	output logic [7:0] sw_select_b_q,
	output logic turnaround_busy_q,
	output irecfg_pkg::irecfg_dma_pins_t dma_pins_q
);
	typedef struct packed {
		logic [3:0] dma_sel;
		logic [7:0] timeout;
		logic [7:0] sw_a;
		logic [7:0] sw_b;
		logic [7:0] cfg_rdata;
		logic [7:0] eng_rdata;
		logic [irecfg_pkg::STEP_CNT_W-1:0] step;
		logic [7:0] units;
		logic busy;
	} irecfg_top_st_t;

	irecfg_top_st_t st_q;
	irecfg_top_st_t st_d;

	logic cfg_hit_dma;
	logic cfg_hit_ta;
	logic cfg_hit_a;
	logic cfg_hit_b;
	logic eng_hit_ta;
	logic eng_hit_a;
	logic eng_hit_b;

	// config-port decoding only counts while the device sits in configuration state; engine decoding ignores mode [RL1]
	assign cfg_hit_dma = cfg_req.mode && cfg_req.index == irecfg_pkg::IDX_DMA_SEL; // [RL1]
	assign cfg_hit_ta = cfg_req.mode && cfg_req.index == irecfg_pkg::IDX_TURNAROUND; // [RL6]
	assign cfg_hit_a = cfg_req.mode && cfg_req.index == irecfg_pkg::IDX_SW_SEL_A; // [RL10]
	assign cfg_hit_b = cfg_req.mode && cfg_req.index == irecfg_pkg::IDX_SW_SEL_B; // [RL11]
	assign eng_hit_ta = eng_req.block == irecfg_pkg::ENG_BLK_TIMEOUT && eng_req.addr == irecfg_pkg::ENG_ADR_TIMEOUT;
	assign eng_hit_a = eng_req.block == irecfg_pkg::ENG_BLK_SW_SEL && eng_req.addr == irecfg_pkg::ENG_ADR_SW_SEL_A;
	assign eng_hit_b = eng_req.block == irecfg_pkg::ENG_BLK_SW_SEL && eng_req.addr == irecfg_pkg::ENG_ADR_SW_SEL_B;

	always_comb begin
		st_d = st_q;
		// engine writes first, so a same-cycle config write lands last and wins
		if (eng_req.wr && eng_hit_ta) begin
			st_d.timeout = eng_req.wdata; // [RL8]
		end
		if (eng_req.wr && eng_hit_a) begin
			st_d.sw_a = eng_req.wdata; // [RL10]
		end
		if (eng_req.wr && eng_hit_b) begin
			st_d.sw_b = eng_req.wdata; // [RL11]
		end
		if (cfg_req.wr) begin
			if (cfg_hit_dma) begin
				st_d.dma_sel = cfg_req.wdata[irecfg_pkg::DMA_SEL_LSB +: irecfg_pkg::DMA_SEL_W]; // [RL4]
			end
			if (cfg_hit_ta) begin
				st_d.timeout = cfg_req.wdata; // [RL8]
			end
			if (cfg_hit_a) begin
				st_d.sw_a = cfg_req.wdata;
			end
			if (cfg_hit_b) begin
				st_d.sw_b = cfg_req.wdata;
			end
		end
		// eng_soft_reset is deliberately not used: the shared copies survive it [RL9]
		// a read in the cycle of a write returns the old value
		if (cfg_req.rd) begin
			st_d.cfg_rdata = irecfg_pkg::RD_UNMAPPED;
			if (cfg_hit_dma) begin
				st_d.cfg_rdata = {4'h0, st_q.dma_sel}; // [RL4]
			end
			if (cfg_hit_ta) begin
				st_d.cfg_rdata = st_q.timeout;
			end
			if (cfg_hit_a) begin
				st_d.cfg_rdata = st_q.sw_a;
			end
			if (cfg_hit_b) begin
				st_d.cfg_rdata = st_q.sw_b;
			end
		end
		if (eng_req.rd) begin
			st_d.eng_rdata = irecfg_pkg::RD_UNMAPPED;
			if (eng_hit_ta) begin
				st_d.eng_rdata = st_q.timeout; // [RL8]
			end
			if (eng_hit_a) begin
				st_d.eng_rdata = st_q.sw_a;
			end
			if (eng_hit_b) begin
				st_d.eng_rdata = st_q.sw_b;
			end
		end
		// turnaround timer: units of 100 us, counted in whole clock steps [RL7]
		// a start while busy reloads the count; spacing of starts is left to the engine
		if (turnaround_start) begin
			st_d.units = st_q.timeout;
			st_d.step = '0;
		end else if (st_q.units != 8'h00) begin
			if (st_q.step == irecfg_pkg::STEP_LAST) begin
				st_d.step = '0;
				st_d.units = st_q.units - 8'h01; // [RL7]
			end else begin
				st_d.step = st_q.step + irecfg_pkg::STEP_CNT_W'(1);
			end
		end
		st_d.busy = st_d.units != 8'h00;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.dma_sel <= irecfg_pkg::RST_DMA_SEL; // [RL2]
			st_q.timeout <= irecfg_pkg::RST_TURNAROUND; // [RL6] [RL9]
			st_q.sw_a <= irecfg_pkg::RST_SW_SEL_A; // [RL10]
			st_q.sw_b <= irecfg_pkg::RST_SW_SEL_B; // [RL11]
		end else begin
			st_q <= st_d;
		end
	end

	// steering has its own flop stage, so the pins lag the select by one cycle
	irecfg_dma_route #(
		.NUM_CH(irecfg_pkg::NUM_DMA_CH)
	) u_route (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.sel(st_q.dma_sel),
		.req(eng_dma_req),
		.pins_q(dma_pins_q)
	);

	assign cfg_rdata_q = st_q.cfg_rdata;
	assign eng_rdata_q = st_q.eng_rdata;
	assign turnaround_timeout_q = st_q.timeout;
	assign sw_select_a_q = st_q.sw_a;
	assign sw_select_b_q = st_q.sw_b;
	assign turnaround_busy_q = st_q.busy;

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	localparam int STEP_CYC = irecfg_pkg::TIMEOUT_STEP_CYC;
	// cleared on each start: a restart while busy is legal and must not read as an overrun
	logic [19:0] busy_run;
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !st_q.busy || turnaround_start) begin
			busy_run <= '0;
		end else begin
			busy_run <= busy_run + 20'h00001;
		end
	end

	property p_rl1_outside_cfg;
		cfg_req.wr && !cfg_req.mode |=> $stable(st_q.dma_sel);
	endproperty
	a_rl1_outside_cfg: assert property (p_rl1_outside_cfg) else $error("dma select changed outside configuration"); // [RL1]

	property p_rl2_reset_value;
		$rose(reset_n) |-> st_q.dma_sel == 4'h0 && dma_pins_q.oe == 4'h0;
	endproperty
	a_rl2_reset_value: assert property (p_rl2_reset_value) else $error("dma select not zero after reset"); // [RL2]

	property p_rl3_channel_pick;
		st_q.dma_sel <= irecfg_pkg::DMA_CODE_CH_D && $stable(st_q.dma_sel)
			|=> dma_pins_q.oe == (4'h1 << $past(st_q.dma_sel));
	endproperty
	a_rl3_channel_pick: assert property (p_rl3_channel_pick) else $error("wrong dma line enabled"); // [RL3]

	property p_rl4_upper_zero;
		cfg_req.rd && cfg_hit_dma |=> cfg_rdata_q[7:4] == 4'h0;
	endproperty
	a_rl4_upper_zero: assert property (p_rl4_upper_zero) else $error("reserved dma bits read nonzero"); // [RL4]

	property p_rl5_one_driver;
		$onehot0(dma_pins_q.oe) && (dma_pins_q.drq & ~dma_pins_q.oe) == 4'h0;
	endproperty
	a_rl5_one_driver: assert property (p_rl5_one_driver) else $error("unselected dma line driven"); // [RL5]

	property p_rl6_read_back;
		cfg_req.rd && cfg_hit_ta && !cfg_req.wr && !eng_req.wr |=> cfg_rdata_q == $past(st_q.timeout);
	endproperty
	a_rl6_read_back: assert property (p_rl6_read_back) else $error("turnaround read back wrong"); // [RL6]

	property p_rl7_duration;
		turnaround_start && st_q.timeout == 8'h01 ##1 !turnaround_start [*7] |-> turnaround_busy_q;
	endproperty
	a_rl7_duration: assert property (p_rl7_duration) else $error("turnaround ended early"); // [RL7]

	property p_rl7_bound;
		busy_run <= 20'(STEP_CYC * 255 + 1);
	endproperty
	a_rl7_bound: assert property (p_rl7_bound) else $error("turnaround ran past maximum"); // [RL7]

	property p_rl8_engine_write;
		eng_req.wr && eng_hit_ta && !(cfg_req.wr && cfg_hit_ta) |=> turnaround_timeout_q == $past(eng_req.wdata);
	endproperty
	a_rl8_engine_write: assert property (p_rl8_engine_write) else $error("engine write missed config copy"); // [RL8]

	property p_rl9_soft_reset;
		eng_soft_reset && !eng_req.wr && !cfg_req.wr |=> $stable(st_q.timeout);
	endproperty
	a_rl9_soft_reset: assert property (p_rl9_soft_reset) else $error("engine reset disturbed timeout"); // [RL9]

	property p_rl10_shared_a;
		eng_req.rd && eng_hit_a |=> eng_rdata_q == $past(sw_select_a_q);
	endproperty
	a_rl10_shared_a: assert property (p_rl10_shared_a) else $error("select a not shared"); // [RL10]

	property p_rl11_shared_b;
		eng_req.wr && eng_hit_b && !(cfg_req.wr && cfg_hit_b) |=> sw_select_b_q == $past(eng_req.wdata);
	endproperty
	a_rl11_shared_b: assert property (p_rl11_shared_b) else $error("select b not shared"); // [RL11]

	property p_rl12_no_drive;
		st_q.dma_sel > irecfg_pkg::DMA_CODE_CH_D |=> dma_pins_q.oe == 4'h0;
	endproperty
	a_rl12_no_drive: assert property (p_rl12_no_drive) else $error("undocumented code drove a line"); // [RL12]

	property p_rl1_no_decode_read;
		cfg_req.rd && !cfg_req.mode |=> cfg_rdata_q == 8'h00;
	endproperty
	a_rl1_no_decode_read: assert property (p_rl1_no_decode_read) else $error("outside read not zero"); // [RL1]

	property p_rl3_drq_follow;
		st_q.dma_sel <= irecfg_pkg::DMA_CODE_CH_D
			|=> dma_pins_q.drq == ($past(eng_dma_req) ? 4'h1 << $past(st_q.dma_sel) : 4'h0);
	endproperty
	a_rl3_drq_follow: assert property (p_rl3_drq_follow) else $error("request not on selected line"); // [RL3]

	property p_rl4_write_mask;
		cfg_req.wr && cfg_hit_dma |=> st_q.dma_sel == $past(cfg_req.wdata[3:0]);
	endproperty
	a_rl4_write_mask: assert property (p_rl4_write_mask) else $error("dma select write wrong"); // [RL4]

	property p_rl6_cfg_write;
		cfg_req.wr && cfg_hit_ta |=> turnaround_timeout_q == $past(cfg_req.wdata);
	endproperty
	a_rl6_cfg_write: assert property (p_rl6_cfg_write) else $error("turnaround write lost"); // [RL6]

	property p_rl7_zero;
		turnaround_start && st_q.timeout == 8'h00 |=> !turnaround_busy_q;
	endproperty
	a_rl7_zero: assert property (p_rl7_zero) else $error("zero timeout ran"); // [RL7]

	property p_rl7_whole_steps;
		$fell(turnaround_busy_q) |-> busy_run % 20'(STEP_CYC) == 20'h00000;
	endproperty
	a_rl7_whole_steps: assert property (p_rl7_whole_steps) else $error("timeout not whole steps"); // [RL7]

	property p_rl8_engine_read;
		eng_req.rd && eng_hit_ta |=> eng_rdata_q == $past(turnaround_timeout_q);
	endproperty
	a_rl8_engine_read: assert property (p_rl8_engine_read) else $error("engine copy differs"); // [RL8]

	property p_rl9_reset_load;
		$rose(reset_n) |-> turnaround_timeout_q == 8'h03 && sw_select_a_q == 8'h00 && sw_select_b_q == 8'h00;
	endproperty
	a_rl9_reset_load: assert property (p_rl9_reset_load) else $error("reset did not load copies"); // [RL9]

	property p_rl10_cfg_write_a;
		cfg_req.wr && cfg_hit_a |=> sw_select_a_q == $past(cfg_req.wdata);
	endproperty
	a_rl10_cfg_write_a: assert property (p_rl10_cfg_write_a) else $error("select a write lost"); // [RL10]

	property p_rl10_engine_write_a;
		eng_req.wr && eng_hit_a && !(cfg_req.wr && cfg_hit_a) |=> sw_select_a_q == $past(eng_req.wdata);
	endproperty
	a_rl10_engine_write_a: assert property (p_rl10_engine_write_a) else $error("engine missed select a"); // [RL10]

	property p_rl11_cfg_write_b;
		cfg_req.wr && cfg_hit_b |=> sw_select_b_q == $past(cfg_req.wdata);
	endproperty
	a_rl11_cfg_write_b: assert property (p_rl11_cfg_write_b) else $error("select b write lost"); // [RL11]

	property p_rl11_engine_read_b;
		eng_req.rd && eng_hit_b |=> eng_rdata_q == $past(sw_select_b_q);
	endproperty
	a_rl11_engine_read_b: assert property (p_rl11_engine_read_b) else $error("engine read of b wrong"); // [RL11]

	property p_rl12_none_quiet;
		st_q.dma_sel == irecfg_pkg::DMA_CODE_NONE |=> dma_pins_q.drq == 4'h0;
	endproperty
	a_rl12_none_quiet: assert property (p_rl12_none_quiet) else $error("none code drove a request"); // [RL12]

	// main scenarios: select change, shared timeout, timer end, none code, soft reset
	c_dma_write: cover property (cfg_req.wr && cfg_hit_dma ##2 dma_pins_q.drq != 4'h0);
	c_engine_timeout: cover property (eng_req.wr && eng_hit_ta ##1 cfg_req.rd && cfg_hit_ta);
	c_turnaround_end: cover property ($fell(turnaround_busy_q));
	c_none_code: cover property (st_q.dma_sel == irecfg_pkg::DMA_CODE_NONE);
	c_soft_reset_kept: cover property (eng_soft_reset ##1 $stable(turnaround_timeout_q));
endmodule

// >>> rtl/irecfg_pkg.sv
// package: register map, reset values, encodings and timing for the ir engine config registers
// How it works
// (RL1) dma select only at config state, index 2c
// (RL2) dma select reads 00 after power-up
// (RL3) low nibble picks dma channel a-d, f none
// (RL4) upper nibble ignores writes, reads zero
// (RL5) unselected dma request lines stay tristated
// (RL6) turnaround at index 2d, resets to 03
// (RL7) timeout equals value times 100 microseconds
// (RL8) write to either timeout copy updates both
// (RL9) power-on reset loads both; engine reset doesn't
// (RL10) select a at 2e, engine block3 addr 05
// (RL11) select b at 2f, engine block3 addr 06
// (RL12) undocumented dma codes drive no request line
package irecfg_pkg;
	localparam logic [7:0] IDX_DMA_SEL = 8'h2c;
	localparam logic [7:0] IDX_TURNAROUND = 8'h2d;
	localparam logic [7:0] IDX_SW_SEL_A = 8'h2e;
	localparam logic [7:0] IDX_SW_SEL_B = 8'h2f;
	localparam logic [3:0] RST_DMA_SEL = 4'h0;
	localparam logic [7:0] RST_TURNAROUND = 8'h03;
	localparam logic [7:0] RST_SW_SEL_A = 8'h00;
	localparam logic [7:0] RST_SW_SEL_B = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam int DMA_SEL_LSB = 0;
	localparam int DMA_SEL_W = 4;
	localparam logic [3:0] DMA_CODE_CH_A = 4'h0;
	localparam logic [3:0] DMA_CODE_CH_D = 4'h3;
	localparam logic [3:0] DMA_CODE_NONE = 4'hf;
	localparam int NUM_DMA_CH = 4;
	localparam logic [2:0] ENG_BLK_TIMEOUT = 3'h5;
	localparam logic [2:0] ENG_ADR_TIMEOUT = 3'h1;
	localparam logic [2:0] ENG_BLK_SW_SEL = 3'h3;
	localparam logic [2:0] ENG_ADR_SW_SEL_A = 3'h5;
	localparam logic [2:0] ENG_ADR_SW_SEL_B = 3'h6;
	localparam int CLK_PERIOD_NS = 40;
	localparam int TIMEOUT_STEP_NS = 100000;
	// least time per step, so round up
	localparam int TIMEOUT_STEP_CYC = (TIMEOUT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_CNT_W = 12;
	localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(TIMEOUT_STEP_CYC - 1);

	typedef struct packed {
		logic mode;
		logic [7:0] index;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} irecfg_cfg_req_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] block;
		logic [2:0] addr;
		logic [7:0] wdata;
	} irecfg_eng_req_t;

	typedef struct packed {
		logic [NUM_DMA_CH-1:0] drq;
		logic [NUM_DMA_CH-1:0] oe;
	} irecfg_dma_pins_t;
endpackage

// >>> rtl/irecfg_dma_route.sv
// dma request steering: one selected line driven, the rest released
`timescale 1ns/1ps
module irecfg_dma_route #(
	parameter int NUM_CH = irecfg_pkg::NUM_DMA_CH
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [3:0] sel,
	input wire logic req,
	output irecfg_pkg::irecfg_dma_pins_t pins_q
);
	typedef struct packed {
		irecfg_pkg::irecfg_dma_pins_t pins;
	} irecfg_route_st_t;

	irecfg_route_st_t st_q;
	irecfg_route_st_t st_d;

	always_comb begin
		st_d = st_q;
		for (int i = 0; i < NUM_CH; i++) begin
			// codes beyond channel d fall through here with no enable [RL12]
			st_d.pins.oe[i] = (sel == 4'(i)); // [RL3] [RL5]
			st_d.pins.drq[i] = (sel == 4'(i)) & req;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pins_q = st_q.pins;
endmodule

// >>> verification/irecfg_host_model.sv
// host model: turns bench commands into one-cycle config data strobes
`timescale 1ns/1ps
module irecfg_host_model (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic wr,
	input wire logic mode,
	input wire logic [7:0] index,
	input wire logic [7:0] wdata,
	output irecfg_pkg::irecfg_cfg_req_t cfg_req
);
	initial cfg_req = '0;
	// index and mode stay set between strobes, as a host leaves them
	always @(posedge ref_clk) begin
		cfg_req.wr <= go & wr;
		cfg_req.rd <= go & ~wr;
		if (go) begin
			cfg_req.mode <= mode;
			cfg_req.index <= index;
			cfg_req.wdata <= wdata;
		end else begin
			// released data toggles so a stale byte never looks valid
			cfg_req.wdata <= ~cfg_req.wdata;
		end
	end
endmodule

// >>> verification/irecfg_tb_top.sv
// self-checking bench for the ir engine config registers
`timescale 1ns/1ps
module irecfg_tb_top;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic h_go = 1'b0, h_wr = 1'b0, h_mode = 1'b0;
	logic [7:0] h_idx = 8'h00, h_wd = 8'h00;
	irecfg_pkg::irecfg_cfg_req_t cfg_req;
	irecfg_pkg::irecfg_eng_req_t eng_req = '0;
	logic eng_soft_reset = 1'b0, eng_dma_req = 1'b0, turnaround_start = 1'b0;
	logic [7:0] cfg_rdata_q, eng_rdata_q, ta_q, sa_q, sb_q, v;
	logic busy_q;
	irecfg_pkg::irecfg_dma_pins_t dma_pins_q;
	int err_count = 0, n_checks = 0, cyc = 0, seed = 32'h0ba8;
	logic [7:0] mdl [4];
	logic [3:0] oe_x;
	always #20 ref_clk = ~ref_clk;
	irecfg_host_model u_host (.ref_clk(ref_clk), .go(h_go), .wr(h_wr), .mode(h_mode), .index(h_idx),
		.wdata(h_wd), .cfg_req(cfg_req));
	irecfg_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_req(cfg_req), .eng_req(eng_req),
		.eng_soft_reset(eng_soft_reset), .eng_dma_req(eng_dma_req), .turnaround_start(turnaround_start),
		.cfg_rdata_q(cfg_rdata_q), .eng_rdata_q(eng_rdata_q), .turnaround_timeout_q(ta_q),
		.sw_select_a_q(sa_q), .sw_select_b_q(sb_q), .turnaround_busy_q(busy_q), .dma_pins_q(dma_pins_q));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic rst;
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		mdl = '{8'h00, 8'h03, 8'h00, 8'h00};
	endtask
	// host access; mode low or an index outside 2c..2f leaves the model alone and reads 00
	task automatic cfg(input logic w, input logic m, input logic [7:0] i, input logic [7:0] d);
		@(posedge ref_clk);
		h_go <= 1'b1;
		h_wr <= w;
		h_mode <= m;
		h_idx <= i;
		h_wd <= d;
		@(posedge ref_clk);
		h_go <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		if (m && i[7:2] == 6'h0b) begin
			if (w) mdl[i[1:0]] = (i[1:0] == 2'd0) ? (d & 8'h0f) : d;
			else chk(cfg_rdata_q, mdl[i[1:0]]);
		end else if (!w) chk(cfg_rdata_q, 8'h00);
	endtask
	task automatic eng(input logic w, input logic [2:0] b, input logic [2:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		@(posedge ref_clk);
		eng_req <= '{wr: w, rd: !w, block: b, addr: a, wdata: d};
		@(posedge ref_clk);
		eng_req <= '{wr: 1'b0, rd: 1'b0, block: b, addr: a, wdata: ~d};
		#1;
		if (!w) chk(eng_rdata_q, exp);
	endtask
	task automatic kick;
		@(posedge ref_clk);
		turnaround_start <= 1'b1;
		@(posedge ref_clk);
		turnaround_start <= 1'b0;
		#1;
	endtask
	// a hang ends the run as a mismatch
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		rst();
		for (int i = 0; i < 4; i++) cfg(1'b0, 1'b1, 8'h2c + 8'(i), 8'h00);
		cfg(1'b1, 1'b0, 8'h2e, 8'h5a);
		cfg(1'b0, 1'b0, 8'h2e, 8'h00);
		cfg(1'b0, 1'b1, 8'h2e, 8'h00);
		cfg(1'b0, 1'b1, 8'h2b, 8'h00);
		cfg(1'b1, 1'b0, 8'h2c, 8'h05);
		cfg(1'b0, 1'b0, 8'h2c, 8'h00);
		cfg(1'b0, 1'b1, 8'h2c, 8'h00);
		for (int c = 0; c < 16; c++) begin
			v = 8'($random(seed));
			@(posedge ref_clk);
			eng_dma_req <= v[0];
			cfg(1'b1, 1'b1, 8'h2c, {v[7:4], 4'(c)});
			cfg(1'b0, 1'b1, 8'h2c, 8'h00);
			oe_x = (c < 4) ? 4'(1 << c) : 4'h0;
			chk({4'h0, dma_pins_q.oe}, {4'h0, oe_x});
			chk({4'h0, dma_pins_q.drq}, {4'h0, v[0] ? oe_x : 4'h0});
		end
		v = 8'($random(seed));
		cfg(1'b1, 1'b1, 8'h2d, v);
		chk(ta_q, v);
		eng(1'b0, 3'h5, 3'h1, 8'h00, v);
		eng(1'b1, 3'h5, 3'h1, ~v, 8'h00);
		mdl[1] = ~v;
		cfg(1'b0, 1'b1, 8'h2d, 8'h00);
		@(posedge ref_clk);
		eng_soft_reset <= 1'b1;
		@(posedge ref_clk);
		eng_soft_reset <= 1'b0;
		cfg(1'b0, 1'b1, 8'h2d, 8'h00);
		for (int k = 0; k < 2; k++) begin
			v = 8'($random(seed));
			cfg(1'b1, 1'b1, 8'h2e + 8'(k), v);
			eng(1'b0, 3'h3, 3'h5 + 3'(k), 8'h00, v);
			eng(1'b1, 3'h3, 3'h5 + 3'(k), ~v, 8'h00);
			mdl[2 + k] = ~v;
			cfg(1'b0, 1'b1, 8'h2e + 8'(k), 8'h00);
		end
		chk(sa_q, mdl[2]);
		chk(sb_q, mdl[3]);
		eng(1'b0, 3'h4, 3'h1, 8'h00, 8'h00);
		// one step of 100 us at 40 ns per cycle
		cfg(1'b1, 1'b1, 8'h2d, 8'h01);
		kick();
		chk({7'h0, busy_q}, 8'h01);
		repeat (irecfg_pkg::TIMEOUT_STEP_CYC - 10) @(posedge ref_clk);
		#1 chk({7'h0, busy_q}, 8'h01);
		repeat (20) @(posedge ref_clk);
		#1 chk({7'h0, busy_q}, 8'h00);
		cfg(1'b1, 1'b1, 8'h2d, 8'h00);
		kick();
		chk({7'h0, busy_q}, 8'h00);
		rst();
		eng(1'b0, 3'h5, 3'h1, 8'h00, 8'h03);
		cfg(1'b0, 1'b1, 8'h2c, 8'h00);
		chk(ta_q, 8'h03);
		close_out();
	end
endmodule
